//--- msc_top.v
// bus interface configuration and access sequencer for rom/sram/dram/general
//
// Summary of operation
// [R1] sram parity enable, reset 0, makes sram parity errors bus errors
// [R2] sram idle-gap bit, reset 1, idles one clock after rom/dram read
// [R3] sram read and write wait codes, reset 111, give 2..6,8,10,12 clocks
// [R4] width 00 on sram or rom means no device; access raises exception
// [R5] rom, general and dram parity enables reset 0 and stay 0 here
// [R6] rom/general idle-gap bits, reset 1, idle one clock after sram/dram read
// [R7] rom read wait code, reset 111, same encoding as sram waits
// [R8] write data setup bit, reset 1, delays general write strobe one unit
// [R9] clock unit bit, reset 0, general timing in one or two clocks
// [R10] general wait 00..11 gives 4..7 units, reset 11
// [R11] general width, reset 11; 00 makes general access raise exception
// [R12] software waits for dram start-up after writing dram config
// [R13] dram page kind, reset 00: fast page or extended-data-out
// [R14] dram scheme: one or two row strobes, lanes by column or write strobe
// [R15] priority bit: data waits for dram line fill when 0, goes first when 1
// [R16] dram cycle length 01 gives 2 clocks, 10 gives 3, reset 10
// [R17] row msb select, reset 000, picks A17..A23 as top row bit
// [R18] row shift 00..11 shifts row down by 8..11 bits
// [R19] column msb select 000..100 picks A08..A12 as top column bit
// [R20] dram width 00 means no dram; access raises exception
// [R21] refresh kind: normal cas-before-ras or self-refresh
// [R22] 10-bit refresh reload, reset 0, sets refresh interval
// [R23] rom select low for rom space, sram select low for sram space
// [R24] address strobe low for general space, dram strobes for dram space
// [R25] refresh counter steps every 16 clocks, requests refresh at zero
// [R26] strobes and select held for the programmed number of clocks
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "msc_defs.vh"
module msc_top (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire fetchReq,
  input wire fetchFill,
  input wire [31:0] fetchAddr,
  input wire dataReq,
  input wire dataWrite,
  input wire [31:0] dataAddr,
  input wire parityErr,
  output reg accDone,
  output reg accIsData,
  output reg accBusErr,
  output reg accExc,
  output wire romSel_n,
  output wire sramSel_n,
  output wire addrStrobe_n,
  output wire readStrobe_n,
  output wire writeStrobe_n,
  output wire [1:0] rowStrobe_n,
  output wire [1:0] colStrobe_n,
  output wire [1:0] dramWrite_n,
  output wire [23:0] memAddr
);
  localparam IDLE = 2'h0;
  localparam GAP = 2'h1;
  localparam ACCESS = 2'h2;
  localparam REFRESH = 2'h3;

  reg [31:0] spaceCfg;
  reg [31:0] dramCfg;
  reg [1:0] state;
  reg [4:0] cnt;
  reg [4:0] curLen;
  reg [31:0] curAddr;
  reg curWrite;
  reg curData;
  reg [3:0] curSpace;
  reg lastRead;
  reg [3:0] lastSpace;
  reg fillLock;
  reg [3:0] preDiv;
  reg [9:0] refCount;
  reg refPending;
  wire [3:0] sramRdLen;
  wire [3:0] sramWrLen;
  wire [3:0] romLen;

  // apb slave: zero-wait, unmapped offsets answer with an error
  wire apbSetup = psel & ~penable;
  wire apbWr = psel & penable & pwrite;
  wire hitSpace = paddr == `MSC_OFS_SPACE;
  wire hitDram = paddr == `MSC_OFS_DRAM;
  wire hitStatus = paddr == `MSC_OFS_STATUS;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hitSpace | hitDram | hitStatus);

  // read data captured in the setup phase
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      prdata <= 32'h0;
    else if (apbSetup)
      prdata <= hitSpace ? spaceCfg : hitDram ? dramCfg : hitStatus ?
        {13'h0, fillLock, state, curSpace, 1'b0, refPending, refCount} :
        32'h0;
  end

  // configuration registers; parity enables other than sram stay 0
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      spaceCfg <= `MSC_SPACE_RESET; // R1 R2 R3 R4 R6 R7 R8 R9 R10 R11
      dramCfg <= `MSC_DRAM_RESET; // R13 R14 R15 R16 R17 R18 R19 R20 R21 R22
    end
    else if (apbWr && hitSpace)
      spaceCfg <= pwdata & `MSC_SPACE_WMASK; // R5
    else if (apbWr && hitDram)
      dramCfg <= pwdata & `MSC_DRAM_WMASK; // R5
  end

  msc_wait_cycles uSramRd (
    .code(spaceCfg[`MSC_S_SRAM_RW]),
    .cycles(sramRdLen)
  );
  msc_wait_cycles uSramWr (
    .code(spaceCfg[`MSC_S_SRAM_WW]),
    .cycles(sramWrLen)
  );
  msc_wait_cycles uRom (
    .code(spaceCfg[`MSC_S_ROM_RW]),
    .cycles(romLen)
  );

  // arbitration between instruction fetch and load/store data
  wire fillBlocks = (fillLock | (fetchReq & fetchFill &
    fetchAddr[31:28] == `MSC_SP_DRAM)) & ~dramCfg[`MSC_D_PRIO];
  wire pickData = dataReq & ~(fetchReq & fillBlocks); // R15
  wire anyReq = dataReq | fetchReq;
  wire [31:0] selAddr = pickData ? dataAddr : fetchAddr;
  wire selWrite = pickData & dataWrite;
  wire [3:0] selSpace = selAddr[31:28];

  // space decode, width check and access length of the selected request
  wire isRom = selSpace == `MSC_SP_ROM;
  wire isSram = selSpace == `MSC_SP_SRAM;
  wire isDram = selSpace == `MSC_SP_DRAM;
  wire isGen = selSpace[3:2] == 2'h1;
  wire unit2 = spaceCfg[`MSC_S_UNIT];
  reg selExc;
  reg [4:0] selLen;
  always @*
  begin
    selExc = 1'b1;
    selLen = 5'h1;
    if (isRom)
    begin
      selExc = spaceCfg[`MSC_S_ROM_WID] == 2'h0; // R4
      selLen = {1'b0, romLen}; // R7
    end
    else if (isSram)
    begin
      selExc = spaceCfg[`MSC_S_SRAM_WID] == 2'h0; // R4
      selLen = {1'b0, selWrite ? sramWrLen : sramRdLen}; // R3
    end
    else if (isDram)
    begin
      selExc = dramCfg[`MSC_D_WID] == 2'h0; // R20
      selLen = dramCfg[`MSC_D_CYCLE] == 2'h1 ? 5'h2 : 5'h3; // R16
    end
    else if (isGen)
    begin
      selExc = spaceCfg[`MSC_S_GEN_WID] == 2'h0; // R11
      selLen = {2'h0, 1'b1, spaceCfg[`MSC_S_GEN_WAIT]} << unit2; // R9 R10
    end
  end

  // an idle clock is needed before sram after a rom/dram read, and before rom/general after an sram/dram read;
  // a launch in the last access cycle follows the access still running
  wire prevRead = state == ACCESS ? ~curWrite : lastRead;
  wire [3:0] prevSpace = state == ACCESS ? curSpace : lastSpace;
  wire prevSd = prevRead & (prevSpace == `MSC_SP_SRAM |
    prevSpace == `MSC_SP_DRAM);
  wire prevRd = prevRead & (prevSpace == `MSC_SP_ROM |
    prevSpace == `MSC_SP_DRAM);
  wire needGap = (isSram & spaceCfg[`MSC_S_SRAM_GAP] & prevRd) | // R2
    (isRom & spaceCfg[`MSC_S_ROM_GAP] & prevSd) | // R6
    (isGen & spaceCfg[`MSC_S_GEN_GAP] & prevSd); // R6

  // refresh interval: prescaler of 16, then reload counter
  wire preTick = &preDiv; // 16-clock prescaler wraps at all ones
  wire refFire = preTick && refCount == 10'h0 &&
    dramCfg[`MSC_D_REF_LOAD] != 10'h0;
  wire refTake = state == REFRESH && cnt == 5'h0;
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      preDiv <= 4'h0;
      refCount <= 10'h0;
      refPending <= 1'b0;
    end
    else
    begin
      preDiv <= preDiv + 4'h1; // R25
      if (preTick)
        refCount <= refCount == 10'h0 ? dramCfg[`MSC_D_REF_LOAD] :
          refCount - 10'h1; // R22 R25
      if (refFire)
        refPending <= 1'b1; // R25
      else if (refTake)
        refPending <= 1'b0;
    end
  end

  // sequencer
  wire lastCyc = cnt == curLen - 5'h1;
  wire selfHold = dramCfg[`MSC_D_REF_KIND] & ~anyReq;
  wire canLaunch = state == IDLE | (state == ACCESS & lastCyc);
  // a refused request waits for idle so its result never merges with a
  // finishing access into one done pulse
  wire launch = canLaunch & anyReq & ~refPending &
    ~(selExc & state == ACCESS);
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state <= IDLE;
      cnt <= 5'h0;
      curLen <= 5'h1;
      curAddr <= 32'h0;
      curWrite <= 1'b0;
      curData <= 1'b0;
      curSpace <= 4'h0;
      lastRead <= 1'b0;
      lastSpace <= 4'h0;
      fillLock <= 1'b0;
      accDone <= 1'b0;
      accIsData <= 1'b0;
      accBusErr <= 1'b0;
      accExc <= 1'b0;
    end
    else
    begin
      accDone <= 1'b0;
      accBusErr <= 1'b0;
      accExc <= 1'b0;
      if (!fetchFill)
        fillLock <= 1'b0;
      if (state == ACCESS && lastCyc)
      begin
        // finish: parity is judged only on reads
        accDone <= 1'b1;
        accIsData <= curData;
        accBusErr <= ~curWrite & parityErr &
          ((curSpace == `MSC_SP_SRAM & spaceCfg[`MSC_S_SRAM_PAR]) | // R1
          (curSpace == `MSC_SP_ROM & spaceCfg[`MSC_S_ROM_PAR]) | // R5
          (curSpace == `MSC_SP_DRAM & dramCfg[`MSC_D_PAR]) | // R5
          (curSpace[3:2] == 2'h1 & spaceCfg[`MSC_S_GEN_PAR])); // R5
        lastRead <= ~curWrite;
        lastSpace <= curSpace;
      end
      else if (state != ACCESS)
        lastRead <= lastRead & (state == IDLE) & ~canLaunch;
      case (state)
        IDLE, ACCESS:
        begin
          if (launch && selExc)
          begin
            accDone <= 1'b1; // R4 R11 R20
            accIsData <= pickData;
            accExc <= 1'b1;
            state <= IDLE;
            lastRead <= 1'b0;
          end
          else if (launch)
          begin
            curAddr <= selAddr;
            curWrite <= selWrite;
            curData <= pickData;
            curSpace <= selSpace;
            curLen <= selLen; // R26
            cnt <= 5'h0;
            state <= needGap ? GAP : ACCESS;
            if (!pickData && fetchFill && isDram)
              fillLock <= 1'b1; // R15
          end
          else if (state == IDLE && refPending)
          begin
            cnt <= 5'h0;
            state <= REFRESH;
          end
          else if (state == ACCESS && !lastCyc)
            cnt <= cnt + 5'h1; // R26
          else
            state <= IDLE;
        end
        GAP:
          state <= ACCESS; // R2 R6
        REFRESH:
        begin
          if (cnt == 5'h0)
            cnt <= 5'h1;
          else if (!selfHold)
            state <= IDLE; // R21
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  // pin decode from the registered access state
  wire busy = state == ACCESS;
  wire curGen = curSpace[3:2] == 2'h1;
  wire curDram = curSpace == `MSC_SP_DRAM;
  wire [4:0] unitLen = unit2 ? 5'h2 : 5'h1;
  wire setupHold = curGen & curWrite & spaceCfg[`MSC_S_SETUP] &
    cnt < unitLen;
  assign romSel_n = ~(busy & curSpace == `MSC_SP_ROM); // R23
  assign sramSel_n = ~(busy & curSpace == `MSC_SP_SRAM); // R23
  assign addrStrobe_n = ~(busy & curGen); // R24
  assign readStrobe_n = ~(busy & ~curDram & ~curWrite);
  assign writeStrobe_n = ~(busy & ~curDram & curWrite & ~setupHold); // R8

  // dram row/column multiplexing
  wire [4:0] rowMsb = 5'h11 + {2'h0, dramCfg[`MSC_D_ROW_MSB]};
  wire [4:0] colMsb = 5'h8 + {2'h0, dramCfg[`MSC_D_COL_MSB]};
  wire [4:0] rowShift = 5'h8 + {3'h0, dramCfg[`MSC_D_ROW_SHIFT]};
  wire [23:0] rowMask = ~(24'hfffffe << rowMsb);
  wire [23:0] colMask = ~(24'hfffffe << colMsb);
  wire [23:0] rowAddr = (curAddr[23:0] & rowMask) >> rowShift; // R17 R18
  wire [23:0] colAddr = curAddr[23:0] & colMask; // R19
  wire colPhase = cnt != 5'h0;
  assign memAddr = busy & curDram ? (colPhase ? colAddr : rowAddr) :
    curAddr[23:0];

  // dram strobes; refresh drives column before row
  wire twoRow = dramCfg[24];
  wire weLanes = dramCfg[25];
  wire bankHi = curAddr[rowMsb + 5'h1];
  wire dramBusy = busy & curDram;
  wire edoEarly = dramCfg[`MSC_D_PAGE] == 2'h1 & lastCyc & ~curWrite;
  wire colOn = dramBusy & colPhase & ~edoEarly; // R13
  wire refOn = state == REFRESH;
  wire rowOn = refOn ? cnt != 5'h0 : dramBusy;
  wire [1:0] rowSel = refOn | ~twoRow ? 2'h3 : (bankHi ? 2'h2 : 2'h1);
  wire [1:0] laneAct = 2'h3;
  assign rowStrobe_n = ~(rowOn ? rowSel : 2'h0); // R14 R24
  assign colStrobe_n = ~(refOn ? 2'h3 :
    (colOn & (~weLanes | ~curWrite) ? laneAct : 2'h0)); // R14 R21
  assign dramWrite_n = ~(colOn & curWrite ?
    (weLanes ? laneAct : 2'h3) : 2'h0); // R14
endmodule

//--- msc_defs.vh
// register map, field positions, reset values and timing counts
`ifndef MSC_DEFS_VH
`define MSC_DEFS_VH
`define MSC_OFS_SPACE 12'h000
`define MSC_OFS_DRAM 12'h004
`define MSC_OFS_STATUS 12'h008
`define MSC_SPACE_RESET 32'h01fc3faf
`define MSC_SPACE_WMASK 32'h03ff3fbf
`define MSC_DRAM_RESET 32'h00400000
`define MSC_DRAM_WMASK 32'h1bffffff
`define MSC_S_SRAM_PAR 25
`define MSC_S_SRAM_GAP 24
`define MSC_S_SRAM_RW 23:21
`define MSC_S_SRAM_WW 20:18
`define MSC_S_SRAM_WID 17:16
`define MSC_S_ROM_PAR 14
`define MSC_S_ROM_GAP 13
`define MSC_S_ROM_RW 12:10
`define MSC_S_ROM_WID 9:8
`define MSC_S_SETUP 7
`define MSC_S_GEN_PAR 6
`define MSC_S_GEN_GAP 5
`define MSC_S_UNIT 4
`define MSC_S_GEN_WAIT 3:2
`define MSC_S_GEN_WID 1:0
`define MSC_D_PAGE 28:27
`define MSC_D_PAR 26
`define MSC_D_SCHEME 25:24
`define MSC_D_PRIO 23
`define MSC_D_CYCLE 22:21
`define MSC_D_ROW_MSB 20:18
`define MSC_D_ROW_SHIFT 17:16
`define MSC_D_COL_MSB 15:13
`define MSC_D_WID 12:11
`define MSC_D_REF_KIND 10
`define MSC_D_REF_LOAD 9:0
`define MSC_SP_ROM 4'h0
`define MSC_SP_SRAM 4'h1
`define MSC_SP_DRAM 4'h2
`define MSC_REFRESH_DIV 16
`define MSC_GEN_BASE 4'h4
`endif

//--- msc_wait_cycles.v
// converts a 3-bit rom/sram wait code into an access length in clocks
`timescale 1ns/100ps
module msc_wait_cycles (
  input wire [2:0] code,
  output reg [3:0] cycles
);
  // 2..6 clocks linearly, then 8, 10 and 12
  always @*
  begin
    case (code)
      3'h5: cycles = 4'h8;
      3'h6: cycles = 4'ha;
      3'h7: cycles = 4'hc;
      default: cycles = {1'b0, code} + 4'h2;
    endcase
  end
endmodule

//--- msc_mem_model.sv
// external memory stand-in: parity fault source and select-length meter
`timescale 1ns/100ps
module msc_mem_model (
  input wire clk_sys,
  input wire romSel_n,
  input wire sramSel_n,
  input wire readStrobe_n,
  input wire injectErr,
  output wire parityErr,
  output reg [3:0] selLen
);
  reg wasSel;
  wire sel = ~romSel_n | ~sramSel_n;
  // a fault is only reported while data is being read back
  assign parityErr = injectErr & sel & ~readStrobe_n;
  // count clocks of an active select, restart at each new select
  always @(posedge clk_sys)
  begin
    wasSel <= sel;
    if (sel)
      selLen <= wasSel ? selLen + 4'h1 : 4'h1;
  end
endmodule

//--- msc_top_chk.sv
// concurrent checks on the configuration block ports
`timescale 1ns/100ps
module msc_top_chk (
  input wire clk_sys,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire accDone,
  input wire accExc,
  input wire accBusErr,
  input wire romSel_n,
  input wire sramSel_n,
  input wire addrStrobe_n
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  sequence s_rom_start;
    $fell(romSel_n);
  endsequence
  sequence s_sram_start;
    $fell(sramSel_n);
  endsequence
  property p_rst_idle;
    disable iff (1'b0) sys_rst |=> romSel_n && sramSel_n && !accDone;
  endproperty
  property p_slverr;
    psel && penable && paddr > 12'h008 |-> pslverr;
  endproperty
  property p_berr_sram;
    accBusErr |-> accDone && !$past(sramSel_n);
  endproperty
  property p_done_pulse;
    accDone |=> !accDone || accExc;
  endproperty
  property p_rom_min;
    s_rom_start |-> !romSel_n ##1 !romSel_n;
  endproperty
  property p_sram_min;
    s_sram_start |-> !sramSel_n ##1 !sramSel_n;
  endproperty
  property p_exc;
    accExc |-> accDone && romSel_n && sramSel_n && addrStrobe_n;
  endproperty
  property p_one_sel;
    !(!romSel_n && !sramSel_n) && !(!addrStrobe_n && !romSel_n);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle in reset");
  a_slverr: assert property (p_slverr) else $error("no slave error");
  a_berr_sram: assert property (p_berr_sram) else $error("bad bus error");
  a_done_pulse: assert property (p_done_pulse) else $error("long done");
  a_rom_min: assert property (p_rom_min) else $error("rom too short");
  a_sram_min: assert property (p_sram_min) else $error("sram short");
  a_exc: assert property (p_exc) else $error("exception selected");
  a_one_sel: assert property (p_one_sel) else $error("two selects");
endmodule
bind msc_top msc_top_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .accDone(accDone), .accExc(accExc), .accBusErr(accBusErr),
  .romSel_n(romSel_n), .sramSel_n(sramSel_n), .addrStrobe_n(addrStrobe_n));

//--- test_memory_space_config.sv
// self-checking bench for the configuration and access sequencer
`timescale 1ns/100ps
module test_memory_space_config;
  reg clk_sys = 0;
  reg sys_rst = 1;
  reg psel = 0, penable = 0, pwrite = 0, injectErr = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, fetchAddr = 0, dataAddr = 0;
  reg fetchReq = 0, dataReq = 0, dataWrite = 0, fetchFill = 0;
  wire [31:0] prdata;
  wire pready, pslverr, parityErr, accDone, accIsData, accBusErr, accExc;
  wire romSel_n, sramSel_n, addrStrobe_n, readStrobe_n;
  wire [3:0] selLen;
  integer mismatches = 0, checks = 0, seed = 92, i;
  logic [32:0] regQ[$];
  logic [6:0] accQ[$];
  logic [6:0] expAcc;
  msc_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetchReq(fetchReq), .fetchFill(fetchFill), .fetchAddr(fetchAddr),
    .dataReq(dataReq), .dataWrite(dataWrite), .dataAddr(dataAddr),
    .parityErr(parityErr), .accDone(accDone), .accIsData(accIsData),
    .accBusErr(accBusErr), .accExc(accExc), .romSel_n(romSel_n),
    .sramSel_n(sramSel_n), .addrStrobe_n(addrStrobe_n),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(), .rowStrobe_n(),
    .colStrobe_n(), .dramWrite_n(), .memAddr());
  msc_mem_model MEM (.clk_sys(clk_sys), .romSel_n(romSel_n),
    .sramSel_n(sramSel_n), .readStrobe_n(readStrobe_n),
    .injectErr(injectErr), .parityErr(parityErr), .selLen(selLen));
  // free-running system clock
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  task check_reg(input [32:0] got, input [32:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t register got %h exp %h", $time, got, exp);
    end
  endtask
  task check_acc(input [6:0] got, input [6:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t access got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; a read notes its expected {slverr, data}
  task apb(input w, input [11:0] a, input [31:0] d, input [32:0] exp);
    if (!w)
      regQ.push_back(exp);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one core access to space sp; notes {isData, exc, berr, select length}
  task acc(input d, input w, input [3:0] sp, input e, input x, input b,
           input [3:0] len);
    reg [31:0] rv;
    rv = $random(seed);
    accQ.push_back({d, x, b, len});
    @(posedge clk_sys);
    injectErr <= e;
    dataWrite <= w;
    dataAddr <= {sp, rv[27:0]};
    fetchAddr <= {sp, rv[27:0]};
    dataReq <= d;
    fetchReq <= !d;
    @(posedge clk_sys);
    dataReq <= 1'b0;
    fetchReq <= 1'b0;
    while (accQ.size() != 0)
      @(posedge clk_sys);
  endtask
  // line fill and data access to dram raised together; notes the order
  task race(input [31:0] cfg, input dFirst);
    reg [31:0] rv;
    rv = $random(seed);
    apb(1, 12'h004, cfg, 0);
    repeat (4) @(posedge clk_sys);
    accQ.push_back({dFirst, 6'h00});
    accQ.push_back({!dFirst, 6'h00});
    fetchFill <= 1'b1;
    fetchAddr <= {4'h2, rv[27:0]};
    dataAddr <= {4'h2, ~rv[27:0]};
    dataWrite <= rv[28];
    fetchReq <= 1'b1;
    dataReq <= 1'b1;
    @(posedge clk_sys);
    if (dFirst)
      dataReq <= 1'b0;
    else
      fetchReq <= 1'b0;
    while (accQ.size() > 1)
      @(posedge clk_sys);
    dataReq <= 1'b0;
    fetchReq <= 1'b0;
    while (accQ.size() != 0)
      @(posedge clk_sys);
    fetchFill <= 1'b0;
  endtask
  // monitor: compare each result with the oldest note
  always @(posedge clk_sys)
  begin
    if (accDone === 1'b1)
    begin
      expAcc = accQ.size() ? accQ.pop_front() : 7'h7f;
      check_acc({accIsData, accExc, accBusErr,
        (expAcc[3:0] == 4'h0 ? 4'h0 : selLen)}, expAcc);
    end
    if (psel && penable && pready === 1'b1 && !pwrite)
      check_reg({pslverr, prdata}, regQ.pop_front());
  end
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches = mismatches + 1;
    print_verdict;
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(0, 12'h000, 0, {1'b0, 32'h01fc3faf});
    apb(0, 12'h004, 0, {1'b0, 32'h00400000});
    apb(0, 12'h00c, 0, {1'b1, 32'h0});
    acc(1, 0, 4'h1, 0, 1, 0, 0);
    $display("reset and exception test done");
    apb(1, 12'h000, 32'h021f3faf, 0);
    apb(0, 12'h000, 0, {1'b0, 32'h021f3faf});
    acc(1, 0, 4'h1, 1, 0, 1, 2);
    acc(1, 1, 4'h1, 0, 0, 0, 12);
    acc(1, 0, 4'h1, 0, 0, 0, 2);
    $display("sram test done");
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1, 12'h000, 32'h021f23af | (i << 10), 0);
      acc(0, 0, 4'h0, 0, 0, 0, (i < 5) ? i + 2 : 2 * i - 2);
    end
    $display("rom wait test done");
    apb(1, 12'h000, 32'h021f7fef, 0);
    apb(0, 12'h000, 0, {1'b0, 32'h021f3faf});
    acc(0, 0, 4'h0, 1, 0, 0, 12);
    apb(1, 12'h004, 32'hfffff800, 0);
    apb(0, 12'h004, 0, {1'b0, 32'h1bfff800});
    $display("parity and dram config test done");
    race(32'hfffff800, 1);
    race(32'h00001800, 0);
    $display("dram priority test done");
    print_verdict;
  end
endmodule
